// >>> hdl/sml_pkg.sv
// Purpose: shared constants for the serial modem-control line block
// Assumes: apb with 32-bit data, word-aligned registers
// Notes:   offsets and field positions used by the design; the bench and checks use literals
package sml_pkg;

    typedef enum logic [1:0]
    {
        SML_OFFLINE,
        SML_DATA_ONLY,
        SML_MODEM_CTRL,
        SML_MODE_RSVD
    } sml_mode_t;

    localparam logic [7:0] SML_OFS_MODE    = 8'h00;
    localparam logic [7:0] SML_OFS_CTRL    = 8'h04;
    localparam logic [7:0] SML_OFS_STATUS  = 8'h08;
    localparam logic [7:0] SML_OFS_RXPORT  = 8'h0c;
    localparam logic [7:0] SML_OFS_TXLATCH = 8'h10;
    localparam logic [7:0] SML_OFS_PINS    = 8'h14;

    localparam int SML_BIT_DSR    = 7;
    localparam int SML_BIT_RTS    = 5;
    localparam int SML_BIT_RLSD   = 7;
    localparam int SML_BIT_DTR    = 3;
    localparam int SML_BIT_SOUT   = 0;
    localparam int SML_BIT_SIN    = 1;
    localparam int SML_BIT_RTSOPT = 2;
    localparam int SML_BIT_TXD    = 0;

    localparam logic [1:0] SML_RST_MODE    = 2'h0;
    localparam logic [7:0] SML_RST_CTRL    = 8'h00;
    localparam logic [7:0] SML_RST_TXLATCH = 8'h00;
    localparam logic       SML_RST_SOUT    = 1'h0;
    localparam logic       SML_RST_RTSOPT  = 1'h1;

endpackage : sml_pkg

// >>> hdl/sml_modem_lines.sv
// Purpose: modem-control line conditioning with apb register access
// Assumes: line inputs synchronous to clk_sys, asserted = 1 internally
// Notes:   apb slave with one wait state, pslverr on unmapped addresses
// Notes on behaviour
// - off-line: transmit data held at mark regardless of pending data
// - data-only: cts, dsr, rlsd forced asserted internally
// - modem control: all lines follow data stream and control bits
// - off-line: rts and dtr deasserted, rxd cts dsr rlsd ignored
// - modem control rts on (code drives rts from control bit 5 instead); data-only rts by option, dtr on
// - sensed dsr appears in status bit 7
// - control bit 5 drives rts
// - sensed carrier detect appears in receiver port bit 7
// - transmitter latch bit 3 drives dtr
// - cts routed to processor serial-in pin
// - processor serial-out pin lights the set-ready lamp
// - without modem control, send and receive always enabled on-line
// - modem control: no transmit until handshake from the modem is seen
`timescale 1ns/100ps
module sml_modem_lines
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        clkEn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // serial data from/to character logic
    input  wire logic        txdSerial,
    output logic             rxdSerial,
    output logic             txEnable,
    output logic             rxEnable,
    // connector lines, 1 = asserted / space
    output logic             txdLine,
    input  wire logic        rxdLine,
    output logic             rtsLine,
    input  wire logic        ctsLine,
    input  wire logic        dsrLine,
    input  wire logic        rlsdLine,
    output logic             dtrLine,
    // processor pins and lamp
    output logic             processor_serial_in_pin,
    output logic             set_ready_lamp
);

    sml_pkg::sml_mode_t modeQ;
    logic [7:0]         ctrlQ;
    logic [7:0]         txLatchQ;
    logic               serialOutQ;
    logic               rtsOptQ;

    logic               ctsEff;
    logic               dsrEff;
    logic               rlsdEff;
    logic               rtsNext;
    logic               dtrNext;
    logic               handshakeOk;
    logic               onLine;
    logic               txPass;

    logic               wrEn;
    logic               rdEn;
    logic               mapped;
    logic [31:0]        rdData;

    // unmapped offsets answer with pslverr and read as zero
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == sml_pkg::SML_OFS_MODE)   || (a == sml_pkg::SML_OFS_CTRL) ||
                   (a == sml_pkg::SML_OFS_STATUS) || (a == sml_pkg::SML_OFS_RXPORT) ||
                   (a == sml_pkg::SML_OFS_TXLATCH) || (a == sml_pkg::SML_OFS_PINS);
    endfunction : isMapped

    // one write strobe per writable register, all cut from the shared enable
    function automatic logic wrHit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
        wrHit = en && (a == ofs);
    endfunction : wrHit

    assign mapped = isMapped(paddr);
    // writes land on the completing access edge only, so each lands once
    assign wrEn   = clkEn && psel && penable && pready && pwrite && mapped;
    assign rdEn   = clkEn && psel && penable && !pwrite;
    assign onLine = (modeQ == sml_pkg::SML_DATA_ONLY) || (modeQ == sml_pkg::SML_MODEM_CTRL);

    // effective inputs per mode
    always_comb
    begin
        ctsEff  = 1'b0;
        dsrEff  = 1'b0;
        rlsdEff = 1'b0;
        unique case (modeQ)
            sml_pkg::SML_DATA_ONLY:
            begin
                ctsEff  = 1'b1;
                dsrEff  = 1'b1;
                rlsdEff = 1'b1;
            end
            sml_pkg::SML_MODEM_CTRL:
            begin
                ctsEff  = ctsLine;
                dsrEff  = dsrLine;
                rlsdEff = rlsdLine;
            end
            default:
            begin
                ctsEff  = 1'b0;
                dsrEff  = 1'b0;
                rlsdEff = 1'b0;
            end
        endcase
    end

    // control outputs per mode
    always_comb
    begin
        rtsNext = 1'b0;
        dtrNext = 1'b0;
        unique case (modeQ)
            sml_pkg::SML_DATA_ONLY:
            begin
                rtsNext = rtsOptQ;
                dtrNext = 1'b1;
            end
            sml_pkg::SML_MODEM_CTRL:
            begin
                // software keeps bit 5 set while in this mode
                rtsNext = ctrlQ[sml_pkg::SML_BIT_RTS];
                dtrNext = txLatchQ[sml_pkg::SML_BIT_DTR];
            end
            default:
            begin
                rtsNext = 1'b0;
                dtrNext = 1'b0;
            end
        endcase
    end

    // transmit gated on seen handshake in modem mode
    assign handshakeOk = ctsEff && dsrEff && dtrNext && rtsNext;
    // data-only has no handshake to wait for, whatever the rts option
    assign txPass = (modeQ == sml_pkg::SML_DATA_ONLY) || (onLine && handshakeOk);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            modeQ   <= sml_pkg::sml_mode_t'(sml_pkg::SML_RST_MODE);
            rtsOptQ <= sml_pkg::SML_RST_RTSOPT;
        end
        else if (wrHit(wrEn, paddr, sml_pkg::SML_OFS_MODE))
        begin
            // reserved code folds to off-line, the safe state
            if (pwdata[1:0] == 2'h3)
            begin
                modeQ <= sml_pkg::SML_OFFLINE;
            end
            else
            begin
                modeQ <= sml_pkg::sml_mode_t'(pwdata[1:0]);
            end
            rtsOptQ <= pwdata[sml_pkg::SML_BIT_RTSOPT];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrlQ <= sml_pkg::SML_RST_CTRL;
        end
        else if (wrHit(wrEn, paddr, sml_pkg::SML_OFS_CTRL))
        begin
            ctrlQ <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            txLatchQ <= sml_pkg::SML_RST_TXLATCH;
        end
        else if (wrHit(wrEn, paddr, sml_pkg::SML_OFS_TXLATCH))
        begin
            txLatchQ <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            serialOutQ <= sml_pkg::SML_RST_SOUT;
        end
        else if (wrHit(wrEn, paddr, sml_pkg::SML_OFS_PINS))
        begin
            serialOutQ <= pwdata[sml_pkg::SML_BIT_SOUT];
        end
    end

    // line outputs, registered; mode change seen one edge later
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            // every line starts as off-line would drive it
            txdLine   <= 1'b0;
            rxdSerial <= 1'b0;
            rtsLine   <= 1'b0;
            dtrLine   <= 1'b0;
            txEnable  <= 1'b0;
            rxEnable  <= 1'b0;
        end
        else if (clkEn)
        begin
            // mark = 0 in this polarity, also while handshake is missing
            txdLine   <= txPass ? txdSerial : 1'b0;
            rxdSerial <= onLine ? rxdLine : 1'b0;
            rtsLine   <= rtsNext;
            dtrLine   <= dtrNext;
            if (modeQ == sml_pkg::SML_DATA_ONLY)
            begin
                txEnable <= 1'b1;
                rxEnable <= 1'b1;
            end
            else
            begin
                txEnable <= onLine && handshakeOk;
                rxEnable <= onLine && rlsdEff && dsrEff;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            processor_serial_in_pin <= 1'b0;
            set_ready_lamp          <= 1'b0;
        end
        else if (clkEn)
        begin
            // registered like the lines, so both pins lag one edge
            processor_serial_in_pin <= ctsEff;
            set_ready_lamp          <= serialOutQ;
        end
    end

    always_comb
    begin
        rdData = 32'h0000_0000;
        unique case (paddr)
            sml_pkg::SML_OFS_MODE:
            begin
                rdData[1:0] = modeQ;
                rdData[sml_pkg::SML_BIT_RTSOPT] = rtsOptQ;
            end
            sml_pkg::SML_OFS_CTRL:    rdData[7:0] = ctrlQ;
            sml_pkg::SML_OFS_STATUS:  rdData[sml_pkg::SML_BIT_DSR]  = dsrEff;
            sml_pkg::SML_OFS_RXPORT:  rdData[sml_pkg::SML_BIT_RLSD] = rlsdEff;
            sml_pkg::SML_OFS_TXLATCH: rdData[7:0] = txLatchQ;
            sml_pkg::SML_OFS_PINS:
            begin
                rdData[sml_pkg::SML_BIT_SOUT] = serialOutQ;
                rdData[sml_pkg::SML_BIT_SIN]  = ctsEff;
            end
            default:                  rdData = 32'h0000_0000;
        endcase
    end

    // one wait state: pready registered, answer at second access edge
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (clkEn)
        begin
            if (psel && penable && !pready)
            begin
                pready  <= 1'b1;
                pslverr <= !mapped;
                // captured here, so it stands for the whole answer cycle
                prdata  <= rdEn ? rdData : 32'h0000_0000;
            end
            else
            begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

endmodule : sml_modem_lines

// >>> dv/sml_modem_lines_sva.sv
// Purpose: line and apb checks
// Assumes: clkEn dropped only while the apb is idle
// Notes:   mode tracked from apb writes
`timescale 1ns/100ps
module sml_modem_lines_sva
(
    // clock, reset and apb
    input wire logic        clk_sys, nrst, clkEn,
    input wire logic        psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // lines
    input wire logic        txdLine, rtsLine, dtrLine, ctsLine,
    input wire logic        rxdSerial, rxEnable, txEnable,
    input wire logic        processor_serial_in_pin
);
    logic [1:0] modeQ;
    logic       off;
    logic       dat;
    logic       mdm;
    // write lands on the completing access edge
    always_ff @(posedge clk_sys or negedge nrst)
        if (!nrst)
            modeQ <= 2'h0;
        else if (psel && penable && pwrite && pready && clkEn && paddr == 8'h00)
            modeQ <= pwdata[1:0];
    assign off = (modeQ == 2'h0) || (modeQ == 2'h3);
    assign dat = (modeQ == 2'h1);
    assign mdm = (modeQ == 2'h2);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_off_lines: assert property (off && $past(off) |-> !txdLine && !rtsLine && !dtrLine)
        else $error("offline drive");
    a_off_ignore: assert property (off && $past(off) |-> !rxdSerial && !rxEnable
        && !processor_serial_in_pin)
        else $error("offline input");
    a_data_forced: assert property (dat && $past(dat) |->
        processor_serial_in_pin && dtrLine && txEnable && rxEnable)
        else $error("data-only force");
    a_cts_route: assert property (mdm && $past(mdm) |->
        processor_serial_in_pin == $past(ctsLine))
        else $error("cts route");
    a_mode_apply: assert property ($rose(dat) |=> dtrLine && txEnable)
        else $error("mode late");
    cover property (pslverr);
    cover property (mdm && processor_serial_in_pin);
    cover property (dat && rtsLine);
endmodule : sml_modem_lines_sva

bind sml_modem_lines sml_modem_lines_sva u_sva (.clk_sys, .nrst, .clkEn, .psel, .penable,
    .pwrite, .pready, .pslverr, .paddr, .pwdata, .txdLine, .rtsLine, .dtrLine, .ctsLine,
    .rxdSerial, .rxEnable, .txEnable, .processor_serial_in_pin);

// >>> dv/sml_modem_partner.sv
// Purpose: modem answering the terminal handshake
// Assumes: lines 1 = asserted
// Notes:   slow delays clear-to-send
`timescale 1ns/100ps
module sml_modem_partner
(
    // bench control
    input wire logic clk_sys, nrst, slow, holdOff,
    // from terminal
    input wire logic rtsLine, dtrLine,
    // to terminal
    output logic     ctsLine, dsrLine, rlsdLine, rxdLine
);
    logic [3:0] waitQ;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            waitQ    <= 4'h0;
            ctsLine  <= 1'b0;
            dsrLine  <= 1'b0;
            rlsdLine <= 1'b0;
            rxdLine  <= 1'b0;
        end
        else
        begin
            dsrLine  <= dtrLine;
            rlsdLine <= dtrLine;
            // no idle level held, so stale data never looks valid
            rxdLine  <= ~rxdLine;
            if (!rtsLine || holdOff)
                waitQ <= 4'h0;
            else if (waitQ != 4'hf)
                waitQ <= waitQ + 4'h1;
            ctsLine  <= (waitQ >= (slow ? 4'hc : 4'h2));
        end
    end
endmodule : sml_modem_partner

// >>> dv/sml_modem_lines_tb.sv
// Purpose: self-checking bench
// Assumes: clkEn dropped only while the apb is idle
// Notes:   table rows, then line tests
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errorCnt++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module sml_modem_lines_tb;
    typedef struct packed {logic wr; logic [7:0] adr; logic [31:0] dat;
        logic [31:0] exp; logic err;} sml_row_t;
    logic        clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic        txdSerial = 0, slow = 0, holdOff = 0, er, clkEn = 1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, rxdSerial, txEnable, rxEnable, txdLine, rxdLine;
    logic        rtsLine, ctsLine, dsrLine, rlsdLine, dtrLine;
    logic        processor_serial_in_pin, set_ready_lamp;
    int          errorCnt = 0, checked = 0;
    sml_row_t rows [12] = '{
        '{1'b0, 8'h00, 32'h0, 32'h4, 1'b0},  // mode reset value
        '{1'b1, 8'h04, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, 8'h04, 32'h0, 32'hff, 1'b0},
        '{1'b1, 8'h10, 32'h8, 32'h0, 1'b0},
        '{1'b0, 8'h10, 32'h0, 32'h8, 1'b0},
        '{1'b1, 8'h14, 32'h3, 32'h0, 1'b0},
        '{1'b0, 8'h14, 32'h0, 32'h1, 1'b0},  // cts bit read-only
        '{1'b1, 8'h08, 32'h80, 32'h0, 1'b0},
        '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h1c, 32'h5, 32'h0, 1'b1}};
    sml_modem_lines u_dut (.clk_sys, .nrst, .clkEn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .txdSerial, .rxdSerial, .txEnable,
        .rxEnable, .txdLine, .rxdLine, .rtsLine, .ctsLine, .dsrLine, .rlsdLine,
        .dtrLine, .processor_serial_in_pin, .set_ready_lamp);
    sml_modem_partner u_modem (.clk_sys, .nrst, .slow, .holdOff, .rtsLine, .dtrLine,
        .ctsLine, .dsrLine, .rlsdLine, .rxdLine);
    initial
        forever #50 clk_sys = ~clk_sys;
    task final_report;
        $display("checks %0d errors %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wt(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : wt
    initial
    begin
        wt(3);
        nrst <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].adr, rows[i].dat, rd, er);
            `CHK(er, rows[i].err)
            if (!rows[i].wr)
                `CHK(rd, rows[i].exp)
        end
        `CHK(set_ready_lamp, 1'b1)
        txdSerial <= 1'b1;
        apb(1'b1, 8'h00, 32'h6, rd, er);
        wt(8);
        `CHK({rtsLine, dtrLine, txdLine}, 3'h7)
        apb(1'b0, 8'h08, 32'h0, rd, er);
        `CHK(rd, 32'h80)
        apb(1'b0, 8'h0c, 32'h0, rd, er);
        `CHK(rd, 32'h80)
        apb(1'b0, 8'h14, 32'h0, rd, er);
        `CHK(rd, 32'h3)
        `CHK(rxdSerial, ~rxdLine)
        holdOff <= 1'b1;
        wt(4);
        `CHK({processor_serial_in_pin, txdLine, txEnable}, 3'h0)
        slow    <= 1'b1;
        holdOff <= 1'b0;
        wt(6);
        `CHK(txdLine, 1'b0)
        wt(14);
        `CHK(txdLine, 1'b1)
        `CHK({txEnable, rxEnable}, 2'h3)
        apb(1'b1, 8'h04, 32'h0, rd, er);
        apb(1'b1, 8'h10, 32'h0, rd, er);
        wt(3);
        `CHK({rtsLine, dtrLine}, 2'h0)
        apb(1'b0, 8'h08, 32'h0, rd, er);
        `CHK(rd, 32'h0)
        holdOff <= 1'b1;
        apb(1'b1, 8'h00, 32'h1, rd, er);
        wt(3);
        `CHK({rtsLine, dtrLine, processor_serial_in_pin, txdLine}, 4'h7)
        apb(1'b1, 8'h00, 32'h5, rd, er);
        wt(3);
        `CHK({rtsLine, txdLine}, 2'h3)
        clkEn     <= 1'b0;
        txdSerial <= 1'b0;
        wt(3);
        `CHK(txdLine, 1'b1)
        clkEn <= 1'b1;
        wt(2);
        `CHK(txdLine, 1'b0)
        txdSerial <= 1'b1;
        apb(1'b1, 8'h00, 32'h3, rd, er);
        wt(3);
        `CHK({rtsLine, dtrLine, txdLine}, 3'h0)
        `CHK(rxdSerial, 1'b0)
        nrst <= 1'b0;
        wt(3);
        nrst <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, rd, er);
        `CHK(rd, 32'h4)
        `CHK(set_ready_lamp, 1'b0)
        final_report;
    end
    initial
    begin
        wt(3000);
        errorCnt++;
        final_report;
    end
endmodule : sml_modem_lines_tb
